// ### tb.sv
// Self-checking bench for one timer channel: registers, counting, lines.
// Assumes tcm_pkg is compiled first; the bench drives every port itself.
`timescale 1ns/100ps
module tb;
  import tcm_pkg::*;
  // One row of the register walk: write, then read back
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [3:0] be;
    logic [31:0] exp;
  } tcm_row_t;
  logic clk_i; // Bench clock, 100 MHz
  logic rstn_i; // Synchronous reset, active low
  tcm_avm_req_t req; // Bus request towards the channel
  tcm_avm_rsp_t rsp; // Bus answer
  logic [8:0] src; // Sources: [4:0] internal, [7:5] external, [8] line B pin
  logic line_a; // Line A pin level
  logic a_o, a_oe, b_o, b_oe; // Line outputs and enables
  int err_count; // Mismatches
  int checked; // Comparisons made
  logic [31:0] rd; // Last read word
  tcm_row_t rows [8]; // Ordinary register cases

  // Device under test; line B pin is src[8]
  tcm_timer_channel #(.CNT_W(16)) dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .avm_i(req), .avm_o(rsp),
    .internal_clock_i(src[4:0]), .ext_clock_i(src[7:5]),
    .io_line_a_i(line_a), .io_line_a_o(a_o), .io_line_a_oe_o(a_oe),
    .io_line_b_i(src[8]), .io_line_b_o(b_o), .io_line_b_oe_o(b_oe));

  // Free-running clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Word compare
  task automatic chk32(string name, logic [31:0] exp, logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk32

  // Single line compare
  task automatic chk1(string name, logic exp, logic got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %b seen %b", name, exp, got);
    end
  endtask : chk1

  // One bus cycle; held until waitrequest is sampled low, bounded wait
  task automatic bus(logic wr, logic [7:0] a, logic [31:0] d, logic [3:0] be);
    int n;
    req <= '{read: ~wr, write: wr, address: a, byteenable: be, writedata: d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (rsp.waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      err_count++;
      $display("ERROR bus answer expected 0 seen 1");
      stop_test();
    end
    rd = rsp.readdata;
    req <= '0;
    // One idle edge so the next request never shares a time step
    @(posedge clk_i);
  endtask : bus

  task automatic wr(logic [7:0] a, logic [31:0] d, logic [3:0] be = 4'hF);
    bus(1'b1, a, d, be);
  endtask : wr

  // Read and compare in one go
  task automatic rchk(string name, logic [7:0] a, logic [31:0] exp);
    bus(1'b0, a, 32'h0, 4'hF);
    chk32(name, exp, rd);
  endtask : rchk

  // Slow pulses on one source, far below the sampling rate
  task automatic pulse(int idx, int n);
    repeat (n) begin
      src[idx] <= 1'b1;
      repeat (4) @(posedge clk_i);
      src[idx] <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
    // Let the synchroniser drain
    repeat (6) @(posedge clk_i);
  endtask : pulse

  // Line A level change, then settle
  task automatic set_a(logic v);
    line_a <= v;
    repeat (8) @(posedge clk_i);
  endtask : set_a

  task automatic end_test(string name);
    $display("test %s done", name);
  endtask : end_test

  // Counts, verdict and end of run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test

  // Hang guard, far above the roughly 1500 cycles the tests need
  initial begin
    repeat (30000) @(posedge clk_i);
    err_count++;
    $display("ERROR watchdog expected finish seen timeout");
    stop_test();
  end

  // Main sequence
  initial begin
    rstn_i = 1'b0;
    req = '0;
    src = 9'h000;
    line_a = 1'b0;
    err_count = 0;
    checked = 0;
    rows = '{'{8'h04, 32'hFFFF_FFFF, 4'hF, 32'hFFFF_FFFF}, '{8'h04, 32'h1234_5678, 4'h1, 32'hFFFF_FF78},
             '{8'h04, 32'h0000_0000, 4'hF, 32'h0000_0000}, '{8'h08, 32'hDEAD_BEEF, 4'hF, 32'h0000_0000},
             '{8'h00, 32'h0000_0000, 4'hF, 32'h0000_0000}, '{8'h1C, 32'h0000_1234, 4'hF, 32'h0000_1234},
             '{8'h14, 32'h0000_0055, 4'hF, 32'h0000_0000}, '{8'h10, 32'h0000_ABCD, 4'hF, 32'h0000_0000}};
    repeat (20) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    // Values after reset
    rchk("mode reset", OFS_MODE, MODE_RST);
    rchk("count reset", OFS_COUNT, WORD_RST);
    chk1("line a enable reset", 1'b0, a_oe);
    end_test("reset");
    // Ordinary register cases
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata, rows[i].be);
      rchk("table read", rows[i].addr, rows[i].exp);
    end
    end_test("register table");
    // Every clock selection, rising edges, count s+1 each time
    wr(OFS_CTRL, 32'h0000_0001);
    for (int s = 0; s < 8; s++) begin
      wr(OFS_MODE, 32'(s));
      wr(OFS_CTRL, 32'h0000_0004);
      rchk("count after trigger", OFS_COUNT, 32'h0);
      pulse(s, s + 1);
      rchk("selected clock count", OFS_COUNT, 32'(s + 1));
    end
    // Falling edges with the invert bit
    wr(OFS_MODE, 32'h0000_0008);
    wr(OFS_CTRL, 32'h0000_0004);
    pulse(0, 5);
    rchk("inverted count", OFS_COUNT, 32'h5);
    end_test("clock select");
    // Gating by external clock 0: closed, then open
    wr(OFS_MODE, 32'h0000_0010);
    wr(OFS_CTRL, 32'h0000_0004);
    pulse(0, 4);
    rchk("gated closed", OFS_COUNT, 32'h0);
    src[5] <= 1'b1;
    pulse(0, 3);
    rchk("gated open", OFS_COUNT, 32'h3);
    src[5] <= 1'b0;
    end_test("burst");
    // Capture: A on rise, B on fall, B load disables the clock
    wr(OFS_MODE, 32'h0009_0080);
    wr(OFS_CTRL, 32'h0000_0004);
    pulse(0, 4);
    set_a(1'b1);
    pulse(0, 2);
    set_a(1'b0);
    pulse(0, 3);
    rchk("capture a", OFS_MATCH_A, 32'h4);
    rchk("capture b", OFS_MATCH_B, 32'h6);
    rchk("count after b load", OFS_COUNT, 32'h6);
    end_test("capture");
    // Waveform: up with trigger at 5, soft trigger sets A and toggles B
    wr(OFS_PERIOD, 32'h5);
    wr(OFS_MODE, 32'hC040_C400);
    wr(OFS_CTRL, 32'h0000_0005);
    repeat (3) @(posedge clk_i);
    chk1("line a set", 1'b1, a_o);
    chk1("line a enable", 1'b1, a_oe);
    chk1("line b toggled", 1'b1, b_o);
    chk1("line b enable", 1'b1, b_oe);
    pulse(0, 8);
    rchk("period wrap", OFS_COUNT, 32'h2);
    wr(OFS_CTRL, 32'h0000_0004);
    repeat (3) @(posedge clk_i);
    chk1("line b toggled back", 1'b0, b_o);
    chk1("line a held", 1'b1, a_o);
    wr(OFS_MODE, 32'hC040_C000);
    repeat (3) @(posedge clk_i);
    chk1("line b as input", 1'b0, b_oe);
    wr(OFS_MODE, 32'h0);
    repeat (3) @(posedge clk_i);
    chk1("capture releases a", 1'b0, a_oe);
    end_test("waveform");
    // Event on external clock 1 restarts the count
    wr(OFS_MODE, 32'h0000_9900);
    wr(OFS_CTRL, 32'h0000_0005);
    pulse(0, 4);
    pulse(6, 1);
    rchk("event restart", OFS_COUNT, 32'h0);
    pulse(0, 2);
    rchk("count after event", OFS_COUNT, 32'h2);
    end_test("event");
    // Capture triggers: line B rising, then line A each edge
    wr(OFS_MODE, 32'h0000_0100);
    pulse(0, 3);
    pulse(8, 1);
    rchk("line b trigger", OFS_COUNT, 32'h0);
    wr(OFS_MODE, 32'h0000_0700);
    pulse(0, 2);
    pulse(8, 1);
    rchk("line b ignored", OFS_COUNT, 32'h2);
    set_a(1'b1);
    rchk("line a rise trigger", OFS_COUNT, 32'h0);
    pulse(0, 1);
    set_a(1'b0);
    rchk("line a fall trigger", OFS_COUNT, 32'h0);
    // Capture: period restart, then B load stops the clock
    wr(OFS_MODE, 32'h0000_4000);
    wr(OFS_CTRL, 32'h0000_0004);
    pulse(0, 7);
    rchk("period restart", OFS_COUNT, 32'h1);
    wr(OFS_MODE, 32'h0004_0040);
    set_a(1'b1);
    pulse(0, 2);
    rchk("b load stop", OFS_COUNT, 32'h1);
    rchk("b load value", OFS_MATCH_B, 32'h1);
    wr(OFS_CTRL, 32'h0000_0004);
    pulse(0, 1);
    rchk("stop not disable", OFS_COUNT, 32'h1);
    set_a(1'b0);
    end_test("capture triggers");
    // Waveform: up-down turn at the period, then stop and disable on it
    wr(OFS_MODE, 32'h0000_E000);
    wr(OFS_CTRL, 32'h0000_0004);
    pulse(0, 8);
    rchk("up-down turn", OFS_COUNT, 32'h2);
    wr(OFS_MODE, 32'h0000_C040);
    wr(OFS_CTRL, 32'h0000_0004);
    pulse(0, 8);
    rchk("period stop", OFS_COUNT, 32'h0);
    wr(OFS_MODE, 32'h0000_8080);
    wr(OFS_CTRL, 32'h0000_0004);
    pulse(0, 7);
    rchk("period disable", OFS_COUNT, 32'h6);
    // Disable wins over enable in one command; the trigger still clears the count
    wr(OFS_CTRL, 32'h0000_0007);
    pulse(0, 2);
    rchk("disable wins", OFS_COUNT, 32'h0);
    end_test("stop and disable");
    // Second reset in mid-run
    rstn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rchk("mode second reset", OFS_MODE, MODE_RST);
    rchk("count second reset", OFS_COUNT, WORD_RST);
    end_test("second reset");
    stop_test();
  end
endmodule : tb

// ### tcm_out_ctl.sv
// Output line controller: set, clear or toggle on four events.
// Assumes event pulses of one clock from the channel logic.
`timescale 1ns/100ps
module tcm_out_ctl (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Events: [0] own match, [1] period, [2] event, [3] soft
  input wire logic en_i,
  input wire logic [3:0] ev_i,
  input wire logic [7:0] act_i,
  // Line level
  output logic lvl_o
);
  import tcm_pkg::*;
  logic next_lvl; // Level after this cycle's events

  // Later events win, so the soft trigger has top priority
  always_comb begin
    next_lvl = lvl_o;
    for (int i = 0; i < 4; i++) begin
      if (ev_i[i]) begin
        case (act_i[2*i +: 2])
          ACT_SET: next_lvl = 1'b1;
          ACT_CLR: next_lvl = 1'b0;
          ACT_TOG: next_lvl = ~lvl_o;
          default: ;
        endcase
      end
    end
  end

  // Level holds while the line is not driven by waveform logic
  always_ff @(posedge clk_i) begin
    if (!rstn_i) lvl_o <= OUT_RST;
    else if (en_i) lvl_o <= next_lvl; // RULE18 RULE19
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  a_set_action: assert property (en_i && ev_i == 4'h1 && act_i[1:0] == ACT_SET |=> lvl_o) // RULE18
    else $error("match set action not applied");
  a_soft_priority: assert property (en_i && ev_i[3] && act_i[7:6] == ACT_CLR |=> !lvl_o) // RULE19
    else $error("soft trigger clear lost");
endmodule : tcm_out_ctl

// ### tcm_pkg.sv
// Shared constants, types and helpers of the timer channel.
// Assumes one 32-bit Avalon-MM slave per channel, byte addressed.
package tcm_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MODE = 8'h04;
  localparam logic [7:0] OFS_COUNT = 8'h10;
  localparam logic [7:0] OFS_MATCH_A = 8'h14;
  localparam logic [7:0] OFS_MATCH_B = 8'h18;
  localparam logic [7:0] OFS_PERIOD = 8'h1C;
  // Control command bits (write only)
  localparam int B_CLKEN = 0;
  localparam int B_CLKDIS = 1;
  localparam int B_SWTRG = 2;
  // Channel mode fields, both modes
  localparam int F_CLK_SEL = 0;
  localparam int B_CLK_INV = 3;
  localparam int F_BURST = 4;
  localparam int B_STOP = 6;
  localparam int B_DIS = 7;
  localparam int F_EDGE = 8;
  localparam int B_WAVE = 15;
  // Capture mode fields
  localparam int B_TRIG_LINE = 10;
  localparam int B_PER_RESTART = 14;
  localparam int F_LOAD_A = 16;
  localparam int F_LOAD_B = 18;
  // Waveform mode fields
  localparam int F_EVT_SRC = 10;
  localparam int B_EVT_RESTART = 12;
  localparam int F_PROFILE = 13;
  localparam int F_OUT_A = 16;
  localparam int F_OUT_B = 24;
  localparam logic [1:0] PROF_UP_TRIG = 2'h2;
  // Output actions
  localparam logic [1:0] ACT_SET = 2'h1;
  localparam logic [1:0] ACT_CLR = 2'h2;
  localparam logic [1:0] ACT_TOG = 2'h3;
  // Index of each line in the synchronised source vector
  localparam int SRC_N = 10;
  localparam logic [3:0] SRC_EXT0 = 4'h5;
  localparam logic [3:0] SRC_LINE_A = 4'h8;
  localparam logic [3:0] SRC_LINE_B = 4'h9;
  // Values after reset
  localparam logic [31:0] MODE_RST = 32'h0000_0000;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic OUT_RST = 1'b0;
  // Count direction
  typedef enum logic {TCM_UP, TCM_DOWN} tcm_dir_t;
  // Avalon-MM request and answer
  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } tcm_avm_req_t;
  typedef struct packed {
    logic waitrequest;
    logic [31:0] readdata;
  } tcm_avm_rsp_t;
  // Edge selection: 01 rising, 10 falling, 11 both
  function automatic logic tcm_edge_hit(input logic [1:0] sel, input logic rise, input logic fall);
    return (sel[0] & rise) | (sel[1] & fall);
  endfunction : tcm_edge_hit
  // Byte-enable merge of a write into a stored word
  function automatic logic [31:0] tcm_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old & ~m) | (wd & m);
  endfunction : tcm_merge
endpackage : tcm_pkg

// ### tcm_sync.sv
// Two-stage synchroniser with edge flags for a group of pins.
// Assumes the inputs are asynchronous to clk_i.
`timescale 1ns/100ps
module tcm_sync #(
  parameter int W = 10
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Pins in, clean levels and edges out
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] lvl_o,
  output logic [W-1:0] rise_o,
  output logic [W-1:0] fall_o
);
  logic [W-1:0] meta; // First stage, read only by lvl_o
  logic [W-1:0] last; // Third stage for edges

  // Shift chain; edges come from stages two and three only
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      meta <= '0;
      lvl_o <= '0;
      last <= '0;
    end else begin
      meta <= d_i;
      lvl_o <= meta;
      last <= lvl_o;
    end
  end

  assign rise_o = lvl_o & ~last;
  assign fall_o = ~lvl_o & last;
endmodule : tcm_sync

// ### tcm_timer_channel.sv
// One 16-bit timer/counter channel with mode register and readback.
// Assumes Avalon-MM master on clk_i; clock sources and lines are pins.
`timescale 1ns/100ps
// Functional notes
// RULE1 - Clock selector picks source; bit 3 inverts edge
// RULE2 - Burst field ANDs clock with external clock
// RULE3 - Capture: B load stops counter clock
// RULE4 - Capture: B load disables counter clock
// RULE5 - Capture: trigger edge none, rise, fall, both
// RULE6 - Capture: bit 10 picks line A or B
// RULE7 - Capture: optional period match restarts counter
// RULE8 - Bit 15 selects capture or waveform mode
// RULE9 - Capture: line A edge loads register A
// RULE10 - Capture: line A edge loads register B
// RULE11 - Waveform: period match stops counter clock
// RULE12 - Waveform: period match disables counter clock
// RULE13 - Waveform: event edge none, rise, fall, both
// RULE14 - Waveform: event source line B or external
// RULE15 - Line B as event source is input only
// RULE16 - Event restart bit makes event a trigger
// RULE17 - Profile field selects up or up-down counting
// RULE18 - Line A actions per event: set/clear/toggle
// RULE19 - Line B actions per event: set/clear/toggle
// RULE20 - Counter value register reads live count
// RULE21 - Up-down without trigger spans zero to 0xFFFF
// RULE22 - Software trigger resets counter and starts clock
// RULE23 - Up with trigger restarts at period value
module tcm_timer_channel #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Register bus
  input wire tcm_pkg::tcm_avm_req_t avm_i,
  output tcm_pkg::tcm_avm_rsp_t avm_o,
  // Counting clock sources
  input wire logic [4:0] internal_clock_i,
  input wire logic [2:0] ext_clock_i,
  // Line A
  input wire logic io_line_a_i,
  output logic io_line_a_o,
  output logic io_line_a_oe_o,
  // Line B
  input wire logic io_line_b_i,
  output logic io_line_b_o,
  output logic io_line_b_oe_o
);
  import tcm_pkg::*;

  // Synchronised source levels and their edges
  logic [SRC_N-1:0] src_lvl;
  logic [SRC_N-1:0] src_rise;
  logic [SRC_N-1:0] src_fall;

  // Stored state
  logic [31:0] mode; // Channel mode register
  logic [CNT_W-1:0] cnt; // Live count
  logic [CNT_W-1:0] ra; // Match / capture A
  logic [CNT_W-1:0] rb; // Match / capture B
  logic [CNT_W-1:0] rc; // Period value
  tcm_dir_t dir; // Up-down direction
  logic started; // Clock started by a trigger
  logic enabled; // Clock enabled by command
  logic gated_q; // Previous gated clock level
  logic [CNT_W-1:0] next_cnt;
  tcm_dir_t next_dir;

  // All pins pass two flops before anything looks at them
  tcm_sync #(
    .W(SRC_N)
  ) u_sync (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .d_i({io_line_b_i, io_line_a_i, ext_clock_i, internal_clock_i}),
    .lvl_o(src_lvl),
    .rise_o(src_rise),
    .fall_o(src_fall)
  );

  // Mode fields; meaning depends on the mode bit
  wire wave = mode[B_WAVE]; // RULE8
  wire [2:0] clk_sel = mode[F_CLK_SEL +: 3];
  wire clk_inv = mode[B_CLK_INV];
  wire [1:0] burst = mode[F_BURST +: 2];
  wire stop_bit = mode[B_STOP];
  wire dis_bit = mode[B_DIS];
  wire [1:0] edge_sel = mode[F_EDGE +: 2];
  wire trig_line = mode[B_TRIG_LINE];
  wire per_restart = mode[B_PER_RESTART];
  wire [1:0] load_a_sel = mode[F_LOAD_A +: 2];
  wire [1:0] load_b_sel = mode[F_LOAD_B +: 2];
  wire [1:0] evt_src = mode[F_EVT_SRC +: 2];
  wire evt_restart = mode[B_EVT_RESTART];
  wire [1:0] profile = mode[F_PROFILE +: 2];

  // Counting clock: select, gate, pick edge
  wire sel_lvl = src_lvl[{1'b0, clk_sel}]; // RULE1
  wire [3:0] gate_idx = SRC_EXT0 - 4'h1 + {2'b00, burst};
  wire gate_lvl = (burst == 2'b00) | src_lvl[gate_idx]; // RULE2
  wire gated = sel_lvl & gate_lvl;
  wire tick = clk_inv ? (gated_q & ~gated) : (~gated_q & gated); // RULE1
  wire run = enabled & started;
  wire step = run & tick;

  // Compares are sampled on counting edges only
  wire cmp_c = step & (cnt == rc);
  wire cmp_a = step & wave & (cnt == ra);
  wire cmp_b = step & wave & (cnt == rb);

  // Bus decode; a write lands on the edge that raises waitrequest again
  wire wq = avm_o.waitrequest;
  wire req = avm_i.read | avm_i.write;
  wire wr = avm_i.write & ~wq;
  wire rd_take = avm_i.read & wq;
  wire [7:0] addr = avm_i.address;
  wire [31:0] wd = avm_i.writedata;
  wire [3:0] be = avm_i.byteenable;
  wire wr_ctrl = wr & (addr == OFS_CTRL) & be[0];
  wire wr_mode = wr & (addr == OFS_MODE);
  // A and B are read only while capturing
  wire wr_ra = wr & (addr == OFS_MATCH_A) & wave;
  wire wr_rb = wr & (addr == OFS_MATCH_B) & wave;
  wire wr_rc = wr & (addr == OFS_PERIOD);
  wire cmd_en = wr_ctrl & wd[B_CLKEN];
  wire cmd_dis = wr_ctrl & wd[B_CLKDIS];
  wire cmd_sw = wr_ctrl & wd[B_SWTRG];

  // Capture mode: trigger line and loads from line A
  wire [3:0] trg_idx = trig_line ? SRC_LINE_A : SRC_LINE_B; // RULE6
  wire cap_trig = ~wave & tcm_edge_hit(edge_sel, src_rise[trg_idx], src_fall[trg_idx]); // RULE5
  wire load_a = ~wave & tcm_edge_hit(load_a_sel, src_rise[SRC_LINE_A], src_fall[SRC_LINE_A]); // RULE9
  wire load_b = ~wave & tcm_edge_hit(load_b_sel, src_rise[SRC_LINE_A], src_fall[SRC_LINE_A]); // RULE10

  // Waveform mode: external event source and edge
  wire [3:0] evt_idx = (evt_src == 2'b00) ? SRC_LINE_B : SRC_EXT0 - 4'h1 + {2'b00, evt_src}; // RULE14
  wire evt = wave & tcm_edge_hit(edge_sel, src_rise[evt_idx], src_fall[evt_idx]); // RULE13
  wire b_is_out = evt_src != 2'b00; // RULE15
  wire updown = wave & profile[0]; // RULE17
  wire [CNT_W-1:0] top = profile[1] ? rc : '1;

  // Everything that resets the count and starts the clock
  wire per_trig = cmp_c & (wave ? (profile == PROF_UP_TRIG) : per_restart); // RULE7 RULE23
  wire ev_trig = evt & evt_restart; // RULE16
  wire trig = cmd_sw | cap_trig | ev_trig | per_trig; // RULE22
  wire stop_ev = stop_bit & (wave ? cmp_c : load_b); // RULE3 RULE11
  wire dis_ev = dis_bit & (wave ? cmp_c : load_b); // RULE4 RULE12

  // Readback mux; unmapped and write-only offsets read zero
  wire [31:0] cnt_word = 32'(cnt);
  wire [31:0] rd_mux = (addr == OFS_MODE) ? mode :
                       (addr == OFS_COUNT) ? cnt_word : // RULE20
                       (addr == OFS_MATCH_A) ? 32'(ra) :
                       (addr == OFS_MATCH_B) ? 32'(rb) :
                       (addr == OFS_PERIOD) ? 32'(rc) : WORD_RST;

  // Next count: a trigger wins over a counting edge
  always_comb begin
    next_cnt = cnt;
    next_dir = dir;
    if (trig) begin
      next_cnt = '0; // RULE22
      next_dir = TCM_UP;
    end else if (step && updown) begin
      case (dir)
        TCM_UP: begin
          // Turn at the top: 0xFFFF or period value
          if (cnt >= top) begin
            next_cnt = cnt - 1'b1; // RULE21
            next_dir = TCM_DOWN;
          end else begin
            next_cnt = cnt + 1'b1;
          end
        end
        TCM_DOWN: begin
          // Turn at zero and climb again
          if (cnt == '0) begin
            next_cnt = cnt + 1'b1; // RULE21
            next_dir = TCM_UP;
          end else begin
            next_cnt = cnt - 1'b1;
          end
        end
        default: next_dir = TCM_UP;
      endcase
    end else if (step) begin
      next_cnt = cnt + 1'b1; // RULE23
    end
  end

  // Counter and direction
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cnt <= '0;
      dir <= TCM_UP;
    end else begin
      cnt <= next_cnt;
      dir <= next_dir;
    end
  end

  // Clock state: stop and disable win over a same-cycle start
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      started <= 1'b0;
      enabled <= 1'b0;
      gated_q <= 1'b0;
    end else begin
      gated_q <= gated;
      if (stop_ev) started <= 1'b0; // RULE3 RULE11
      else if (trig) started <= 1'b1; // RULE7 RULE16 RULE22
      if (cmd_dis || dis_ev) enabled <= 1'b0; // RULE4 RULE12
      else if (cmd_en) enabled <= 1'b1;
    end
  end

  // Software registers and capture loads
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      mode <= MODE_RST;
      ra <= '0;
      rb <= '0;
      rc <= '0;
    end else begin
      if (wr_mode) mode <= tcm_merge(mode, wd, be);
      if (load_a) ra <= cnt; // RULE9
      else if (wr_ra) ra <= CNT_W'(tcm_merge(32'(ra), wd, be));
      if (load_b) rb <= cnt; // RULE10
      else if (wr_rb) rb <= CNT_W'(tcm_merge(32'(rb), wd, be));
      if (wr_rc) rc <= CNT_W'(tcm_merge(32'(rc), wd, be));
    end
  end

  // One wait cycle per request; read data caught with it
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      avm_o.waitrequest <= 1'b1;
      avm_o.readdata <= WORD_RST;
    end else begin
      avm_o.waitrequest <= ~(req & wq);
      if (rd_take) avm_o.readdata <= rd_mux; // RULE20
    end
  end

  // Line drivers: A drives in waveform mode, B only as output
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      io_line_a_oe_o <= 1'b0;
      io_line_b_oe_o <= 1'b0;
    end else begin
      io_line_a_oe_o <= wave; // RULE8
      io_line_b_oe_o <= wave & b_is_out; // RULE15
    end
  end

  // Line A output actions
  tcm_out_ctl u_out_a (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .en_i(wave),
    .ev_i({cmd_sw, evt, cmp_c, cmp_a}),
    .act_i(mode[F_OUT_A +: 8]),
    .lvl_o(io_line_a_o)
  );

  // Line B output actions; frozen while B is an event input
  tcm_out_ctl u_out_b (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .en_i(wave & b_is_out), // RULE15
    .ev_i({cmd_sw, evt, cmp_c, cmp_b}),
    .act_i(mode[F_OUT_B +: 8]),
    .lvl_o(io_line_b_o)
  );

  // Checks on counter and clock behaviour
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  a_soft_trig_zero: assert property (cmd_sw |=> cnt == '0) // RULE22
    else $error("soft trigger did not clear count");
  a_soft_trig_start: assert property (cmd_sw && !stop_ev |=> started) // RULE22
    else $error("soft trigger did not start clock");
  a_period_restart: assert property (!wave && per_restart && cmp_c |=> cnt == '0 && started) // RULE7
    else $error("period match restart missing");
  a_period_ignored: assert property (!wave && !per_restart && cmp_c && !trig |=> cnt == $past(cnt) + 1'b1) // RULE7
    else $error("period match acted without restart bit");
  a_b_load_stop: assert property (!wave && stop_bit && load_b |=> !started) // RULE3
    else $error("B load did not stop clock");
  a_b_load_dis: assert property (!wave && dis_bit && load_b |=> !enabled) // RULE4
    else $error("B load did not disable clock");
  a_period_stop: assert property (wave && stop_bit && cmp_c |=> !started ##1 cnt == $past(cnt)) // RULE11
    else $error("period match did not stop clock");
  a_period_dis: assert property (wave && dis_bit && cmp_c && !cmd_en |=> !enabled) // RULE12
    else $error("period match did not disable clock");
  a_updown_turn: assert property (updown && !profile[1] && step && dir == TCM_UP && cnt == '1 && !trig // RULE21
                                  |=> cnt == ~CNT_W'(1) && dir == TCM_DOWN)
    else $error("up-down turn at top wrong");
  a_up_wrap: assert property (wave && profile == 2'h0 && step && cnt == '1 && !trig |=> cnt == '0) // RULE23
    else $error("up count did not wrap");
  a_b_input: assert property (wave && !b_is_out |=> !io_line_b_oe_o) // RULE15
    else $error("line B driven while event input");
  a_count_read: assert property (rd_take && addr == OFS_COUNT |=> avm_o.readdata == 32'($past(cnt))) // RULE20
    else $error("count readback wrong");
  // Bus answers after exactly one wait, then waits again
  a_one_wait: assert property (req && wq |=> !wq) // RULE20
    else $error("no answer after one wait");
  a_wait_back: assert property (!wq |=> wq) // RULE20
    else $error("waitrequest low twice");

  // Line-driven triggers and loads; a wrong trigger or event pin pick fails here
  a_cap_trig: assert property (cap_trig && !stop_ev |=> cnt == '0 && started) // RULE5
    else $error("capture trigger lost");
  a_trig_line_a: assert property (!wave && trig_line && edge_sel[1] && src_fall[SRC_LINE_A] |-> cap_trig) // RULE6
    else $error("line A trigger missed");
  a_trig_line_b: assert property (!wave && !trig_line && edge_sel[0] && src_rise[SRC_LINE_B] |-> cap_trig) // RULE6
    else $error("line B trigger missed");
  a_load_a: assert property (load_a |=> ra == $past(cnt)) // RULE9
    else $error("A load wrong");
  a_load_b: assert property (load_b |=> rb == $past(cnt)) // RULE10
    else $error("B load wrong");
  a_evt_restart: assert property (ev_trig && !stop_ev |=> cnt == '0 && started) // RULE16
    else $error("event restart lost");
  a_evt_ext: assert property (wave && evt_src == 2'b10 && edge_sel[0] && src_rise[SRC_EXT0 + 4'h1] |-> evt) // RULE14
    else $error("external event missed");
  a_evt_line_b: assert property (wave && evt_src == 2'b00 && edge_sel[1] && src_fall[SRC_LINE_B] |-> evt) // RULE13
    else $error("line B event missed");
  // Line B as an input must not move, capture drives nothing
  a_b_frozen: assert property (wave && !b_is_out |=> $stable(io_line_b_o)) // RULE15
    else $error("line B level moved as input");
  a_cap_lines: assert property (!wave |=> !io_line_a_oe_o && !io_line_b_oe_o) // RULE8
    else $error("line driven in capture");
  // Up-down turning points and a halted clock
  a_updown_top: assert property (updown && profile[1] && step && dir == TCM_UP // RULE17
                                 && cnt == rc && !trig |=> dir == TCM_DOWN)
    else $error("up-down no turn at period");
  a_updown_floor: assert property (updown && step && dir == TCM_DOWN && cnt == '0 && !trig // RULE21
                                   |=> cnt == CNT_W'(1) && dir == TCM_UP)
    else $error("up-down no turn at zero");
  a_halt_count: assert property (!run && !trig |=> cnt == $past(cnt)) // RULE11 RULE12
    else $error("count moved while halted");

  c_soft_trig: cover property (cmd_sw ##1 step);
  c_updown_turn: cover property (updown && step && dir == TCM_UP ##1 dir == TCM_DOWN);
  c_capture_b: cover property (!wave && load_b && stop_bit);
  c_period_trig: cover property (wave && per_trig);
  c_event_restart: cover property (ev_trig && started);
endmodule : tcm_timer_channel
